// file: inc/mmsr_pkg.sv
// mmsr_pkg: address map, register offsets, reset values and carrier structs
// for the monitor-controller memory map and low system-register bank.
// assumes: single 8-bit cpu bus, 16-bit addresses.
package mmsr_pkg;

    // -----------------------------------------------------------------
    // address map
    // -----------------------------------------------------------------
    localparam logic [15:0] MMSR_SYS_BASE = 16'h0000;
    localparam logic [15:0] MMSR_SYS_LAST = 16'h003D;
    localparam logic [15:0] MMSR_RAM_BASE = 16'h0080;
    localparam logic [15:0] MMSR_RAM_LAST = 16'h027F;
    localparam logic [15:0] MMSR_BOOT_BASE = 16'h7800;
    localparam logic [15:0] MMSR_BOOT_LAST = 16'h7FFF;
    localparam logic [15:0] MMSR_FLASH_BASE = 16'h8000;
    localparam logic [15:0] MMSR_FLASH_LAST = 16'hFFFF;
    localparam logic [15:0] MMSR_STACK_DEFAULT = 16'h01FF;
    localparam logic [7:0] MMSR_STACK_INIT = 8'hFF;

    // vector offsets within the top page of boot rom or flash
    localparam logic [7:0] MMSR_VEC_NMI = 8'hFA;
    localparam logic [7:0] MMSR_VEC_RST = 8'hFC;
    localparam logic [7:0] MMSR_VEC_IRQ = 8'hFE;

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [15:0] MMSR_PORT0_DATA = 16'h0000;
    localparam logic [15:0] MMSR_PORT1_DATA = 16'h0001;
    localparam logic [15:0] MMSR_PORT2_DIRECTION = 16'h0002;
    localparam logic [15:0] MMSR_PORT2_DATA = 16'h0003;
    localparam logic [15:0] MMSR_PORT3_DATA = 16'h0004;
    localparam logic [15:0] MMSR_PORT4_DATA = 16'h0005;
    localparam logic [15:0] MMSR_SYNC_INPUT_CONTROL = 16'h0006;
    localparam logic [15:0] MMSR_SYNC_POLARITY_CONTROL = 16'h0007;
    localparam logic [15:0] MMSR_HFREQ_COUNT_LOW = 16'h0008;
    localparam logic [15:0] MMSR_HFREQ_COUNT_HIGH = 16'h0009;
    localparam logic [15:0] MMSR_VFREQ_COUNT_LOW = 16'h000A;
    localparam logic [15:0] MMSR_VFREQ_COUNT_HIGH = 16'h000B;
    localparam logic [15:0] MMSR_FREE_RUN_CONTROL = 16'h000C;
    localparam logic [15:0] MMSR_HALF_FREQ_CONTROL = 16'h000D;
    localparam logic [15:0] MMSR_MUTE_CONTROL = 16'h000E;
    localparam logic [15:0] MMSR_PWM_PIN_ENABLE = 16'h000F;
    localparam logic [15:0] MMSR_CONVERTER_CONTROL = 16'h0010;
    localparam logic [15:0] MMSR_CONVERTER_RESULT0 = 16'h0011;
    localparam logic [15:0] MMSR_CONVERTER_RESULT3 = 16'h0014;

    // -----------------------------------------------------------------
    // reset values and field masks
    // -----------------------------------------------------------------
    localparam logic [7:0] MMSR_RST_ONES = 8'hFF;
    localparam logic [7:0] MMSR_RST_PORT1 = 8'h7F;
    localparam logic [7:0] MMSR_RST_PORT34 = 8'h03;
    localparam logic [7:0] MMSR_RST_ZERO = 8'h00;
    localparam logic [7:0] MMSR_MASK_PORT1 = 8'h7F;
    localparam logic [7:0] MMSR_MASK_PORT34 = 8'h03;
    localparam logic [7:0] MMSR_MASK_SYNC_RD = 8'h0B;
    localparam logic [7:0] MMSR_MASK_POL_WR = 8'hC3;
    localparam logic [7:0] MMSR_MASK_FREE_RUN = 8'hC7;
    localparam logic [7:0] MMSR_MASK_HALF = 8'hE0;
    localparam logic [7:0] MMSR_MASK_MUTE = 8'hEF;
    localparam logic [7:0] MMSR_MASK_PWM = 8'h3F;
    localparam logic [7:0] MMSR_MASK_CONV = 8'h8F;
    localparam logic [7:0] MMSR_MASK_RESULT = 8'h3F;
    localparam int MMSR_BIT_OVF = 7;
    localparam int MMSR_BIT_SEL_WE = 2;
    localparam int MMSR_BIT_SEL = 1;
    localparam int MMSR_BIT_START = 7;

    // memory region selected by an address
    typedef enum logic [2:0] {
        MMSR_REG_SYS,
        MMSR_REG_RAM,
        MMSR_REG_BOOT,
        MMSR_REG_FLASH,
        MMSR_REG_NONE
    } mmsr_region_t;

    // cpu bus request
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mmsr_req_t;

    // status coming in from the sync processor and converter
    typedef struct packed {
        logic horiz_input_level;
        logic vert_input_level;
        logic horiz_input_polarity;
        logic vert_input_polarity;
        logic [11:0] hcount;
        logic hcount_ovf_evt;
        logic [13:0] vcount;
        logic vcount_ovf_evt;
        logic [3:0][5:0] result;
    } mmsr_stat_t;

    // control out to the peripherals
    typedef struct packed {
        logic [7:0] port0;
        logic [7:0] port1;
        logic [7:0] port2_pin_output_enable;
        logic [7:0] port2;
        logic [7:0] port3;
        logic [7:0] port4;
        logic [7:0] sync_input;
        logic [1:0] sync_output_enable;
        logic horiz_output_polarity;
        logic vert_output_polarity;
        logic [7:0] free_run;
        logic [7:0] half_freq;
        logic [7:0] mute;
        logic [5:0] pwm_output_enable;
        logic conversion_start;
        logic [3:0] converter_channel_enable;
    } mmsr_ctl_t;

endpackage

// file: verilog/mmsr_top.sv
// mmsr_top: address decoder, data ram and low system-register bank.
// assumes: cpu bus synchronous to sys_clk_i, one access per cycle, read data
// one cycle after the request; status inputs come from logic on this clock.
// Operation
// R01: ram decoded at 0x0080 to 0x027F
// R02: ram neither initialised nor reset
// R03: stack defaults 0x01FF, software loads 0xFF
// R04: boot rom decoded at 0x7800 to 0x7FFF
// R05: top six boot bytes hold vectors
// R06: nmi, reset, irq vectors, low first
// R07: flash decoded at 0x8000 to 0xFFFF
// R08: software supplies flash vector words itself
// R09: registers below 0x003E, gaps unused
// R10: port2 direction write-only, resets all ones
// R11: port4 data holds bits 1 and 0
// R12: sync control readback, bit2 select write-enable
// R13: polarity read: levels, detected, programmed polarities
// R14: polarity write: output enables, output polarities
// R15: 12/14-bit counts, overflow in bit 7
// R16: writing one to bit 7 clears overflow
// R17: free-run control write-only fields
// R18: half-frequency control write-only fields
// R19: auto-mute control write-only fields
// R20: pwm pin enable write-only, resets ones
// R21: converter control: start and channel enables
// R22: converter results read-only, six bits
// R23: unused ranges: no side effect
`timescale 1ns/1ps
module mmsr_top
    import mmsr_pkg::*;
#(
    parameter int RAM_WORDS = 512,
    parameter int BOOT_WORDS = 2048
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire mmsr_req_t req_i,
    input wire mmsr_stat_t stat_i,
    input wire logic [7:0] boot_rdata_i,
    input wire logic [7:0] flash_rdata_i,
    output logic [7:0] rdata_o,
    output logic boot_rd_o,
    output logic flash_rd_o,
    output logic [14:0] mem_addr_o,
    output mmsr_ctl_t ctl_o
);

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    if (RAM_WORDS != 512) begin : g_ram_chk
        $error("ram depth must match the decoded range");
    end
    if (BOOT_WORDS != 2048) begin : g_boot_chk
        $error("boot depth must match the decoded range");
    end

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        mmsr_ctl_t ctl;
        logic hovf;
        logic vovf;
        logic [7:0] rdata;
        logic boot_rd;
        logic flash_rd;
        logic [14:0] mem_addr;
        logic [1:0] rsel;
    } mmsr_state_t;

    mmsr_state_t st_r;
    mmsr_state_t st_nxt;
    mmsr_region_t region;
    logic [7:0] reg_rdata;
    logic [8:0] ram_idx;
    logic [7:0] ram_q_r;

    // data ram, no reset so contents survive system reset [R02]
    logic [7:0] ram_mem [RAM_WORDS];

    // region decode, shared by read and write paths
    function automatic mmsr_region_t decode(input logic [15:0] a);
        if (a <= MMSR_SYS_LAST) begin
            decode = MMSR_REG_SYS; // [R09]
        end else if (a >= MMSR_RAM_BASE && a <= MMSR_RAM_LAST) begin
            decode = MMSR_REG_RAM; // [R01]
        end else if (a >= MMSR_BOOT_BASE && a <= MMSR_BOOT_LAST) begin
            decode = MMSR_REG_BOOT; // [R04]
        end else if (a >= MMSR_FLASH_BASE) begin
            decode = MMSR_REG_FLASH; // [R07]
        end else begin
            decode = MMSR_REG_NONE; // [R09]
        end
    endfunction

    // masked write helper
    function automatic logic [7:0] wmask(input logic [7:0] d, input logic [7:0] m);
        wmask = d & m;
    endfunction

    assign region = decode(req_i.addr);
    assign ram_idx = 9'(req_i.addr - MMSR_RAM_BASE);

    // -----------------------------------------------------------------
    // ram port; the stack page 0x0100-0x01FF lies inside it, so the
    // default stack at 0x01FF and the 0xFF load both land here [R03]
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (region == MMSR_REG_RAM && req_i.wr) begin
            ram_mem[ram_idx] <= req_i.wdata; // [R01]
        end
        ram_q_r <= ram_mem[ram_idx];
    end

    // -----------------------------------------------------------------
    // register read mux
    // -----------------------------------------------------------------
    always_comb begin
        reg_rdata = MMSR_RST_ZERO;
        unique case (req_i.addr)
            MMSR_PORT0_DATA: reg_rdata = st_r.ctl.port0;
            MMSR_PORT1_DATA: reg_rdata = st_r.ctl.port1 & MMSR_MASK_PORT1;
            MMSR_PORT2_DATA: reg_rdata = st_r.ctl.port2;
            MMSR_PORT3_DATA: reg_rdata = st_r.ctl.port3 & MMSR_MASK_PORT34;
            MMSR_PORT4_DATA: reg_rdata = st_r.ctl.port4 & MMSR_MASK_PORT34; // [R11]
            MMSR_SYNC_INPUT_CONTROL: reg_rdata = st_r.ctl.sync_input & MMSR_MASK_SYNC_RD; // [R12]
            MMSR_SYNC_POLARITY_CONTROL: reg_rdata = {2'b00, stat_i.horiz_input_level,
                stat_i.vert_input_level, stat_i.horiz_input_polarity,
                stat_i.vert_input_polarity, st_r.ctl.horiz_output_polarity,
                st_r.ctl.vert_output_polarity}; // [R13]
            MMSR_HFREQ_COUNT_LOW: reg_rdata = stat_i.hcount[7:0]; // [R15]
            MMSR_HFREQ_COUNT_HIGH: reg_rdata = {st_r.hovf, 3'b000, stat_i.hcount[11:8]}; // [R15]
            MMSR_VFREQ_COUNT_LOW: reg_rdata = stat_i.vcount[7:0];
            MMSR_VFREQ_COUNT_HIGH: reg_rdata = {st_r.vovf, 1'b0, stat_i.vcount[13:8]}; // [R15]
            default: begin
                if (req_i.addr >= MMSR_CONVERTER_RESULT0 && req_i.addr <= MMSR_CONVERTER_RESULT3) begin
                    reg_rdata = {2'b00, stat_i.result[2'(req_i.addr - MMSR_CONVERTER_RESULT0)]}; // [R22]
                end
            end
        endcase
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.boot_rd = 1'b0;
        st_nxt.flash_rd = 1'b0;
        st_nxt.ctl.conversion_start = 1'b0;
        // overflow events set, set wins over a same-cycle clear
        if (region == MMSR_REG_SYS && req_i.wr) begin
            unique case (req_i.addr)
                MMSR_PORT0_DATA: st_nxt.ctl.port0 = req_i.wdata;
                MMSR_PORT1_DATA: st_nxt.ctl.port1 = wmask(req_i.wdata, MMSR_MASK_PORT1);
                MMSR_PORT2_DIRECTION: st_nxt.ctl.port2_pin_output_enable = req_i.wdata; // [R10]
                MMSR_PORT2_DATA: st_nxt.ctl.port2 = req_i.wdata;
                MMSR_PORT3_DATA: st_nxt.ctl.port3 = wmask(req_i.wdata, MMSR_MASK_PORT34);
                MMSR_PORT4_DATA: st_nxt.ctl.port4 = wmask(req_i.wdata, MMSR_MASK_PORT34); // [R11]
                MMSR_SYNC_INPUT_CONTROL: begin
                    // interval select only changes when its write-enable is set [R12]
                    st_nxt.ctl.sync_input = (st_r.ctl.sync_input & ~MMSR_MASK_SYNC_RD)
                        | (req_i.wdata & MMSR_MASK_SYNC_RD);
                    if (!req_i.wdata[MMSR_BIT_SEL_WE]) begin
                        st_nxt.ctl.sync_input[MMSR_BIT_SEL] = st_r.ctl.sync_input[MMSR_BIT_SEL];
                    end
                end
                MMSR_SYNC_POLARITY_CONTROL: begin
                    st_nxt.ctl.sync_output_enable = req_i.wdata[7:6]; // [R14]
                    st_nxt.ctl.horiz_output_polarity = req_i.wdata[1];
                    st_nxt.ctl.vert_output_polarity = req_i.wdata[0];
                end
                MMSR_HFREQ_COUNT_HIGH: begin
                    if (req_i.wdata[MMSR_BIT_OVF]) begin
                        st_nxt.hovf = 1'b0; // [R16]
                    end
                end
                MMSR_VFREQ_COUNT_HIGH: begin
                    if (req_i.wdata[MMSR_BIT_OVF]) begin
                        st_nxt.vovf = 1'b0; // [R16]
                    end
                end
                MMSR_FREE_RUN_CONTROL: st_nxt.ctl.free_run = wmask(req_i.wdata, MMSR_MASK_FREE_RUN); // [R17]
                MMSR_HALF_FREQ_CONTROL: st_nxt.ctl.half_freq = wmask(req_i.wdata, MMSR_MASK_HALF); // [R18]
                MMSR_MUTE_CONTROL: st_nxt.ctl.mute = wmask(req_i.wdata, MMSR_MASK_MUTE); // [R19]
                MMSR_PWM_PIN_ENABLE: st_nxt.ctl.pwm_output_enable = req_i.wdata[5:0]; // [R20]
                MMSR_CONVERTER_CONTROL: begin
                    st_nxt.ctl.conversion_start = req_i.wdata[MMSR_BIT_START]; // [R21]
                    st_nxt.ctl.converter_channel_enable = req_i.wdata[3:0];
                end
                default: begin
                    // read-only and unmapped system offsets drop the write [R23]
                end
            endcase
        end
        if (stat_i.hcount_ovf_evt) begin
            st_nxt.hovf = 1'b1; // [R15]
        end
        if (stat_i.vcount_ovf_evt) begin
            st_nxt.vovf = 1'b1; // [R15]
        end
        // rom and flash fetch strobes; vectors sit at FA..FF of each top page,
        // low byte first, served from the array contents [R05] [R06] [R08]
        if (req_i.rd && region == MMSR_REG_BOOT) begin
            st_nxt.boot_rd = 1'b1;
            st_nxt.mem_addr = 15'(req_i.addr - MMSR_BOOT_BASE);
        end
        if (req_i.rd && region == MMSR_REG_FLASH) begin
            st_nxt.flash_rd = 1'b1;
            st_nxt.mem_addr = 15'(req_i.addr - MMSR_FLASH_BASE);
        end
        // read data captured for registers; ram follows its own port
        st_nxt.rsel = 2'd0;
        if (req_i.rd) begin
            unique case (region)
                MMSR_REG_SYS: st_nxt.rdata = reg_rdata;
                MMSR_REG_RAM: st_nxt.rsel = 2'd1;
                MMSR_REG_BOOT: st_nxt.rsel = 2'd2;
                MMSR_REG_FLASH: st_nxt.rsel = 2'd3;
                MMSR_REG_NONE: st_nxt.rdata = MMSR_RST_ONES; // [R23]
            endcase
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.ctl.port0 <= MMSR_RST_ONES;
            st_r.ctl.port1 <= MMSR_RST_PORT1;
            st_r.ctl.port2_pin_output_enable <= MMSR_RST_ONES; // [R10]
            st_r.ctl.port2 <= MMSR_RST_ONES;
            st_r.ctl.port3 <= MMSR_RST_PORT34;
            st_r.ctl.port4 <= MMSR_RST_PORT34;
            st_r.ctl.sync_input <= MMSR_RST_ONES;
            st_r.ctl.sync_output_enable <= 2'b11;
            st_r.ctl.horiz_output_polarity <= 1'b1;
            st_r.ctl.vert_output_polarity <= 1'b1;
            st_r.ctl.free_run <= MMSR_RST_ONES;
            st_r.ctl.half_freq <= MMSR_RST_ONES;
            st_r.ctl.mute <= MMSR_RST_ONES;
            st_r.ctl.pwm_output_enable <= 6'h3F; // [R20]
            st_r.ctl.conversion_start <= 1'b0;
            st_r.ctl.converter_channel_enable <= 4'hF;
            st_r.hovf <= 1'b0;
            st_r.vovf <= 1'b0;
            st_r.rdata <= MMSR_RST_ZERO;
            st_r.boot_rd <= 1'b0;
            st_r.flash_rd <= 1'b0;
            st_r.mem_addr <= 15'h0000;
            st_r.rsel <= 2'd0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    always_comb begin
        unique case (st_r.rsel)
            2'd1: rdata_o = ram_q_r;
            2'd2: rdata_o = boot_rdata_i;
            2'd3: rdata_o = flash_rdata_i;
            default: rdata_o = st_r.rdata;
        endcase
    end
    assign boot_rd_o = st_r.boot_rd;
    assign flash_rd_o = st_r.flash_rd;
    assign mem_addr_o = st_r.mem_addr;
    assign ctl_o = st_r.ctl;

endmodule

// file: dv/mmsr_top_asserts.sv
// mmsr_top_asserts: concurrent checks on the ports of mmsr_top.
// assumes: bound into mmsr_top, one clock, async active-high reset.
`timescale 1ns/1ps
module mmsr_top_asserts
    import mmsr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire mmsr_req_t req_i,
    input wire mmsr_stat_t stat_i,
    input wire logic [7:0] boot_rdata_i,
    input wire logic [7:0] flash_rdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic boot_rd_o,
    input wire logic flash_rd_o,
    input wire logic [14:0] mem_addr_o,
    input wire mmsr_ctl_t ctl_o
);
    // --------------------
    // helpers
    // --------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    // controls without the start pulse
    mmsr_ctl_t ctl_k;
    always_comb begin
        ctl_k = ctl_o;
        ctl_k.conversion_start = 1'b0;
    end

    // --------------------
    // properties
    // --------------------
    property p_boot_dec;
        req_i.rd && req_i.addr[15:11] == 5'h0F |=>
            boot_rd_o && !flash_rd_o && mem_addr_o[10:0] == $past(req_i.addr[10:0]);
    endproperty
    a_boot_dec: assert property (p_boot_dec) else $error("boot read not decoded");
    property p_flash_dec;
        req_i.rd && req_i.addr[15] |=> flash_rd_o && !boot_rd_o && mem_addr_o == $past(req_i.addr[14:0]);
    endproperty
    a_flash_dec: assert property (p_flash_dec) else $error("flash read not decoded");
    property p_low_dec;
        req_i.rd && req_i.addr < MMSR_BOOT_BASE |=> !boot_rd_o && !flash_rd_o;
    endproperty
    a_low_dec: assert property (p_low_dec) else $error("memory strobe on low read");
    property p_mem_data;
        (boot_rd_o || flash_rd_o) |-> rdata_o == (boot_rd_o ? boot_rdata_i : flash_rdata_i);
    endproperty
    a_mem_data: assert property (p_mem_data) else $error("memory data not passed");
    property p_dir;
        req_i.wr && req_i.addr == MMSR_PORT2_DIRECTION |=> ctl_o.port2_pin_output_enable == $past(req_i.wdata);
    endproperty
    a_dir: assert property (p_dir) else $error("direction write lost");
    property p_pwm;
        req_i.wr && req_i.addr == MMSR_PWM_PIN_ENABLE |=> ctl_o.pwm_output_enable == $past(req_i.wdata[5:0]);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm enable write lost");
    property p_start;
        req_i.wr && req_i.addr == MMSR_CONVERTER_CONTROL && req_i.wdata[7] |=> ctl_o.conversion_start ##1
            !ctl_o.conversion_start;
    endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_result;
        req_i.rd && req_i.addr >= MMSR_CONVERTER_RESULT0 && req_i.addr <= MMSR_CONVERTER_RESULT3 |=>
            rdata_o[5:0] == $past(stat_i.result[req_i.addr[2:0] - 3'h1]);
    endproperty
    a_result: assert property (p_result) else $error("converter result wrong");
    property p_noctl;
        req_i.wr && req_i.addr > MMSR_SYS_LAST |=> $stable(ctl_k);
    endproperty
    a_noctl: assert property (p_noctl) else $error("control changed by outside write");
endmodule

bind mmsr_top mmsr_top_asserts mmsr_top_asserts_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .stat_i(stat_i), .boot_rdata_i(boot_rdata_i),
    .flash_rdata_i(flash_rdata_i), .rdata_o(rdata_o), .boot_rd_o(boot_rd_o), .flash_rd_o(flash_rd_o),
    .mem_addr_o(mem_addr_o), .ctl_o(ctl_o)
);

// file: dv/mmsr_mem_model.sv
// mmsr_mem_model: boot rom and flash behind the memory strobes.
// assumes: data wanted while a strobe is high and the cycle after.
`timescale 1ns/1ps
module mmsr_mem_model (
    input wire logic sys_clk_i,
    input wire logic boot_rd_i,
    input wire logic flash_rd_i,
    input wire logic [14:0] mem_addr_i,
    output logic [7:0] boot_rdata_o,
    output logic [7:0] flash_rdata_o
);
    logic boot_q = 1'b0, flash_q = 1'b0;
    logic [7:0] junk_r = 8'h00;
    // late strobes and a changing pattern for released data
    always @(posedge sys_clk_i) begin
        boot_q <= boot_rd_i;
        flash_q <= flash_rd_i;
        junk_r <= junk_r + 8'h3B;
    end
    // contents incl. vector bytes at the top of each page
    assign boot_rdata_o = (boot_rd_i || boot_q) ? mem_addr_i[7:0] ^ 8'h5A : junk_r;
    assign flash_rdata_o = (flash_rd_i || flash_q) ? mem_addr_i[7:0] ^ 8'hA5 : ~junk_r;
endmodule

// file: dv/mmsr_top_tb.sv
// mmsr_top_tb: table-driven bench for mmsr_top.
// assumes: mmsr_mem_model answers the memory strobes.
`timescale 1ns/1ps
module mmsr_top_tb;
    import mmsr_pkg::*;
    typedef struct packed {
        logic [15:0] a;
        logic [7:0] w;
        logic [7:0] r;
        logic [7:0] m;
    } mmsr_row_t;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    mmsr_req_t req_i = '0;
    mmsr_stat_t stat_i = '{1'b1, 1'b0, 1'b1, 1'b0, 12'h5A3, 1'b0, 14'h2C61, 1'b0, '{6'h01, 6'h3F, 6'h2A, 6'h15}};
    logic [7:0] boot_rdata, flash_rdata, rdata_o;
    logic boot_rd, flash_rd;
    logic [14:0] mem_addr;
    logic [15:0] ha;
    mmsr_ctl_t ctl_o, e;
    int n_mismatch = 0, checked = 0, cyc = 0;
    string nm;
    // write data, read expectation, read mask
    mmsr_row_t rows [$] = '{
        '{16'h0000, 8'hA5, 8'hA5, 8'hFF}, '{16'h0001, 8'hFF, 8'h7F, 8'h7F}, '{16'h0002, 8'h5A, 8'h00, 8'h00},
        '{16'h0003, 8'h3C, 8'h3C, 8'hFF}, '{16'h0004, 8'hFE, 8'h02, 8'h03}, '{16'h0005, 8'hFD, 8'h01, 8'h03},
        '{16'h0006, 8'h04, 8'h00, 8'h0F}, '{16'h0006, 8'h0A, 8'h08, 8'h0F}, '{16'h0007, 8'h42, 8'h2A, 8'h3F},
        '{16'h0008, 8'h77, 8'hA3, 8'hFF}, '{16'h000A, 8'h11, 8'h61, 8'hFF}, '{16'h000C, 8'h45, 8'h00, 8'h00},
        '{16'h000D, 8'h40, 8'h00, 8'h00}, '{16'h000E, 8'hA9, 8'h00, 8'h00}, '{16'h000F, 8'h15, 8'h00, 8'h00},
        '{16'h0010, 8'h85, 8'h00, 8'h00}, '{16'h0011, 8'h00, 8'h15, 8'h3F}, '{16'h0012, 8'h00, 8'h2A, 8'h3F},
        '{16'h0013, 8'h00, 8'h3F, 8'h3F}, '{16'h0014, 8'h00, 8'h01, 8'h3F}, '{16'h0015, 8'h33, 8'h00, 8'hFF},
        '{16'h003E, 8'h33, 8'hFF, 8'hFF}, '{16'h0080, 8'hC3, 8'hC3, 8'hFF}, '{16'h01FF, 8'h99, 8'h99, 8'hFF},
        '{16'h027F, 8'h66, 8'h66, 8'hFF}, '{16'h0280, 8'h66, 8'hFF, 8'hFF}, '{16'h7800, 8'h12, 8'h5A, 8'hFF},
        '{16'h7FFA, 8'h12, 8'hA0, 8'hFF}, '{16'h7FFF, 8'h12, 8'hA5, 8'hFF}, '{16'h8000, 8'h12, 8'hA5, 8'hFF},
        '{16'hFFFC, 8'h12, 8'h59, 8'hFF}, '{16'hFFFF, 8'h12, 8'h5A, 8'hFF}};

    always #2.5 sys_clk_i = ~sys_clk_i;

    mmsr_top mmsr_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .stat_i(stat_i),
        .boot_rdata_i(boot_rdata), .flash_rdata_i(flash_rdata), .rdata_o(rdata_o), .boot_rd_o(boot_rd),
        .flash_rd_o(flash_rd), .mem_addr_o(mem_addr), .ctl_o(ctl_o));
    mmsr_mem_model mmsr_mem_model_i (.sys_clk_i(sys_clk_i), .boot_rd_i(boot_rd), .flash_rd_i(flash_rd),
        .mem_addr_i(mem_addr), .boot_rdata_o(boot_rdata), .flash_rdata_o(flash_rdata));

    // --------------------
    // tasks
    // --------------------
    task automatic end_of_test();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // byte compare under a mask
    task automatic chk8(input string n, input logic [7:0] x, input logic [7:0] g, input logic [7:0] m);
        checked++;
        if ((g & m) !== (x & m)) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", n, x & m, g & m);
        end
    endtask

    // sync control is checked by read-back
    function automatic mmsr_ctl_t cmask(input mmsr_ctl_t c);
        c.sync_input = 8'h00;
        return c;
    endfunction

    task automatic chk_ctl();
        checked++;
        if (cmask(ctl_o) !== cmask(e)) begin
            n_mismatch++;
            $display("unexpected ctl_o: expected %h seen %h", cmask(e), cmask(ctl_o));
        end
    endtask

    // expected effect of a write on the controls
    task automatic model_wr(input logic [15:0] a, input logic [7:0] d);
        e.conversion_start = 1'b0;
        case (a)
            MMSR_PORT0_DATA: e.port0 = d;
            MMSR_PORT1_DATA: e.port1 = d & MMSR_MASK_PORT1;
            MMSR_PORT2_DIRECTION: e.port2_pin_output_enable = d;
            MMSR_PORT2_DATA: e.port2 = d;
            MMSR_PORT3_DATA: e.port3 = d & MMSR_MASK_PORT34;
            MMSR_PORT4_DATA: e.port4 = d & MMSR_MASK_PORT34;
            MMSR_SYNC_POLARITY_CONTROL: begin
                e.sync_output_enable = d[7:6];
                e.horiz_output_polarity = d[1];
                e.vert_output_polarity = d[0];
            end
            MMSR_FREE_RUN_CONTROL: e.free_run = d & MMSR_MASK_FREE_RUN;
            MMSR_HALF_FREQ_CONTROL: e.half_freq = d & MMSR_MASK_HALF;
            MMSR_MUTE_CONTROL: e.mute = d & MMSR_MASK_MUTE;
            MMSR_PWM_PIN_ENABLE: e.pwm_output_enable = d[5:0];
            MMSR_CONVERTER_CONTROL: begin
                e.conversion_start = d[7];
                e.converter_channel_enable = d[3:0];
            end
            default: ;
        endcase
    endtask

    // one access, result settled on return
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        req_i <= '{a, w, !w, d};
        @(posedge sys_clk_i);
        req_i <= '0;
        #1;
    endtask

    task automatic do_reset();
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        #1;
        e = '1;
        e.port1 = 8'h7F;
        e.port3 = 8'h03;
        e.port4 = 8'h03;
        e.conversion_start = 1'b0;
        chk_ctl();
        chk8("strobes", 8'h00, {6'h00, boot_rd, flash_rd}, 8'hFF);
    endtask

    // --------------------
    // sequence
    // --------------------
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        do_reset();
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w);
            model_wr(rows[i].a, rows[i].w);
            chk_ctl();
            bus(1'b0, rows[i].a, 8'h00);
            nm = $sformatf("rdata_o at %h", rows[i].a);
            chk8(nm, rows[i].r, rdata_o, rows[i].m);
        end
        // back to back: write, read it, read another
        @(posedge sys_clk_i);
        req_i <= '{MMSR_RAM_BASE, 1'b1, 1'b0, 8'h55};
        @(posedge sys_clk_i);
        req_i <= '{MMSR_RAM_BASE, 1'b0, 1'b1, 8'h00};
        @(posedge sys_clk_i);
        req_i <= '{MMSR_STACK_DEFAULT, 1'b0, 1'b1, 8'h00};
        #1;
        chk8("ram back to back", 8'h55, rdata_o, 8'hFF);
        @(posedge sys_clk_i);
        req_i <= '0;
        #1;
        chk8("stack top", 8'h99, rdata_o, 8'hFF);
        // sticky overflow, then clear by bit 7
        for (int k = 0; k < 2; k++) begin
            ha = k ? MMSR_VFREQ_COUNT_HIGH : MMSR_HFREQ_COUNT_HIGH;
            @(posedge sys_clk_i);
            stat_i.hcount_ovf_evt <= (k == 0);
            stat_i.vcount_ovf_evt <= (k == 1);
            @(posedge sys_clk_i);
            stat_i.hcount_ovf_evt <= 1'b0;
            stat_i.vcount_ovf_evt <= 1'b0;
            bus(1'b0, ha, 8'h00);
            chk8("count high set", k ? 8'hAC : 8'h85, rdata_o, k ? 8'hBF : 8'h8F);
            bus(1'b1, ha, 8'h80);
            bus(1'b0, ha, 8'h00);
            chk8("count high cleared", k ? 8'h2C : 8'h05, rdata_o, k ? 8'hBF : 8'h8F);
        end
        // ram survives a second reset
        do_reset();
        bus(1'b0, MMSR_RAM_BASE, 8'h00);
        chk8("ram after reset", 8'h55, rdata_o, 8'hFF);
        end_of_test();
    end
endmodule
